// ==== pllsw_pkg.sv ====
// How it works
// R01: Prescale and feedback dividers each accept integer settings from 1 through 512.
// R02: Prescale divider only divides frequency; it has no duty control.
// R03: Five output dividers drive the global clock network outputs.
// R04: Half-duty output divider accepts divide values 1 through 512.
// R05: Other-duty output divider accepts divide values 1 through 256 only.
// R06: Output period is high count plus low count; they set duty.
// R07: An output divider may be clocked by the previous one, multiplying division.
// R08: Divider chaining is fixed at build time, not by register writes.
// R09: Duty step is one half divided by the divide value.
// R10: A silent current reference makes the logic select the backup reference.
// R11: Status shows a lost flag per reference and the active reference.
// R12: Automatic switching may repeat back and forth without limit.
// R13: Fabric must switch manually when references differ by more than 20%.
// R14: Lost flag rises after about two reference periods without toggling.
// R15: On loss, the state machine drives the mux select to the backup.
// R16: The mux change happens on a falling edge of the available reference.
// R17: Manual request rising edge starts a switch; hold high three slow cycles.
// R18: Manual switch gates on old falling edge, switches on new falling edge.
// R19: Active indicator follows manual request; no lost flag while both run.
// R20: Request falling edge never switches back; each rising edge repeats.
// R21: Switch completes only once the target reference is available.
// R22: A held manual request blocks automatic switching.
// R23: Reset selects the primary reference and clears both lost flags.
package pllsw_pkg;
   localparam int CLK_HZ = 40000000;
   localparam int DIV_W = 10;
   localparam int SIL_W = 16;
   localparam logic [DIV_W-1:0] DIV_MIN = 10'h001;
   localparam logic [DIV_W-1:0] DIV_MAX = 10'h200;
   localparam logic [DIV_W-1:0] DIV_MAX_SKEW = 10'h100;
   localparam logic [DIV_W-1:0] DIV_RESET = 10'h001;
   localparam int N_OUT = 5;
   localparam logic [SIL_W-1:0] LOSS_INIT_CYC = 16'h0FFF;

   // Register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_PRESCALE = 8'h04;
   localparam logic [7:0] OFS_FEEDBACK = 8'h08;
   localparam logic [7:0] OFS_ODIV0 = 8'h0C;
   localparam logic [7:0] OFS_CASCADE = 8'h20;
   localparam logic [7:0] ODIV_STRIDE = 8'h04;

   // Output divider field positions
   localparam int ODIV_DIV_LSB = 0;
   localparam int ODIV_HIGH_LSB = 10;
   localparam int ODIV_HALF_BIT = 20;

   // Status bit positions
   localparam int ST_LOST0_BIT = 0;
   localparam int ST_LOST1_BIT = 1;
   localparam int ST_ACTIVE_BIT = 2;
   localparam int ST_GATED_BIT = 3;
   localparam int ST_STATE_LSB = 4;

   typedef enum logic [1:0] {
      SW_RUN = 2'b00,
      SW_GATE = 2'b01,
      SW_LAND = 2'b10
   } pllsw_state_t;

   typedef struct packed {
      logic half_duty;
      logic [DIV_W-1:0] high_half;
      logic [DIV_W-1:0] div;
   } pllsw_odiv_t;

   localparam pllsw_odiv_t ODIV_RESET = '{half_duty: 1'b1, high_half: 10'h001, div: 10'h001};

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } pllsw_wbreq_t;
endpackage

// ==== pllsw_ref_src.sv ====
`timescale 1ns/1ps
// Reference source; stands still low while stopped
module pllsw_ref_src #(
   parameter int HALF = 4
) (
   input wire logic clk_i,
   input wire logic run_i,
   output logic ref_o
);
   int cnt = 0;
   initial ref_o = 1'b0;
   always @(posedge clk_i) begin
      if (!run_i) begin
         ref_o <= 1'b0;
         cnt <= 0;
      end else if (cnt == HALF - 1) begin
         ref_o <= ~ref_o;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // pllsw_ref_src

// ==== pllsw_top.sv ====
`timescale 1ns/1ps
module pllsw_top
   import pllsw_pkg::*;
#(
   parameter logic [N_OUT-1:0] CASCADE = 5'h00
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire pllsw_wbreq_t wb_req_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Reference inputs, fabric request and VCO tick
   input wire logic primary_ref_clock_i,
   input wire logic secondary_ref_clock_i,
   input wire logic switch_req_i,
   input wire logic vco_tick_i,
   // Status to fabric
   output logic ref0_lost_flag_o,
   output logic ref1_lost_flag_o,
   output logic active_sel_o,
   // Clock outputs
   output logic ref_clk_o,
   output logic pfd_ref_o,
   output logic pfd_fb_o,
   output logic [N_OUT-1:0] global_clock_network_o
);

   function automatic logic odiv_ok(input pllsw_odiv_t c);
      if (c.half_duty)
         return (c.div >= DIV_MIN) && (c.div <= DIV_MAX);
      return (c.div >= DIV_MIN) && (c.div <= DIV_MAX_SKEW) && (c.high_half >= DIV_MIN)
         && ({1'b0, c.high_half} < {c.div, 1'b0});
   endfunction

   function automatic logic div_ok(input logic [DIV_W-1:0] v);
      return (v >= DIV_MIN) && (v <= DIV_MAX);
   endfunction

   // ---------------- Register bus ----------------
   logic ack_ff;
   logic [31:0] rdat_ff;
   logic [DIV_W-1:0] pre_ff;
   logic [DIV_W-1:0] fb_ff;
   pllsw_odiv_t odiv_ff [N_OUT];
   logic bus_go;
   logic wr_go;
   pllsw_odiv_t wr_odiv;
   logic [31:0] status_w;
   pllsw_state_t st_ff;
   logic sel_ff;
   logic gated_ff;
   logic [1:0] lost_ff;

   assign bus_go = wb_req_i.cyc && wb_req_i.stb && !ack_ff;
   assign wr_go = bus_go && wb_req_i.we && (wb_req_i.sel == 4'hF);
   assign wr_odiv = pllsw_odiv_t'(wb_req_i.dat[ODIV_HALF_BIT:0]);
   assign status_w = {24'h000000, 2'h0, st_ff, gated_ff, sel_ff, lost_ff[1], lost_ff[0]};
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i)
         ack_ff <= 1'b0;
      else
         ack_ff <= bus_go;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_ff <= 32'h00000000;
      end else if (bus_go && !wb_req_i.we) begin
         rdat_ff <= 32'h00000000;
         if (wb_req_i.adr == OFS_STATUS)
            rdat_ff <= status_w;
         else if (wb_req_i.adr == OFS_PRESCALE)
            rdat_ff <= {22'h000000, pre_ff};
         else if (wb_req_i.adr == OFS_FEEDBACK)
            rdat_ff <= {22'h000000, fb_ff};
         else if (wb_req_i.adr == OFS_CASCADE)
            rdat_ff <= {27'h0000000, CASCADE};
         else
            for (int i = 0; i < N_OUT; i++)
               if (wb_req_i.adr == OFS_ODIV0 + ODIV_STRIDE * 8'(i))
                  rdat_ff <= {11'h000, odiv_ff[i]};
      end
   end

   // Out-of-range settings are dropped so the dividers never see them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_ff <= DIV_RESET;
         fb_ff <= DIV_RESET;
      end else if (wr_go) begin
         if (wb_req_i.adr == OFS_PRESCALE && div_ok(wb_req_i.dat[DIV_W-1:0])) // R01
            pre_ff <= wb_req_i.dat[DIV_W-1:0];
         else if (wb_req_i.adr == OFS_FEEDBACK && div_ok(wb_req_i.dat[DIV_W-1:0])) // R01
            fb_ff <= wb_req_i.dat[DIV_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < N_OUT; i++)
            odiv_ff[i] <= ODIV_RESET;
      end else if (wr_go) begin
         for (int i = 0; i < N_OUT; i++)
            if (wb_req_i.adr == OFS_ODIV0 + ODIV_STRIDE * 8'(i) && odiv_ok(wr_odiv)) // R04 R05
               odiv_ff[i] <= wr_odiv;
      end
   end

   // ---------------- Reference sensing ----------------
   logic [1:0] ref_ff;
   logic [1:0] ref_q_ff;
   logic [1:0] rise;
   logic [1:0] fall;
   logic [SIL_W-1:0] sil_ff [2];
   logic [SIL_W-1:0] per_ff [2];

   assign rise = ref_ff & ~ref_q_ff;
   assign fall = ref_q_ff & ~ref_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_ff <= 2'h0;
         ref_q_ff <= 2'h0;
      end else begin
         ref_ff <= {secondary_ref_clock_i, primary_ref_clock_i};
         ref_q_ff <= ref_ff;
      end
   end

   // Silence is judged against each input's own last period
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int k = 0; k < 2; k++) begin
            sil_ff[k] <= '0;
            per_ff[k] <= '0;
         end
      end else begin
         for (int k = 0; k < 2; k++) begin
            if (rise[k]) begin
               sil_ff[k] <= '0;
               // An outage is no period; a long one would slow the next loss check
               if (!lost_ff[k])
                  per_ff[k] <= sil_ff[k]; // R14
            end else if (sil_ff[k] != '1) begin
               sil_ff[k] <= sil_ff[k] + 16'h0001;
            end
         end
      end
   end

   function automatic logic silent(input logic [SIL_W-1:0] s, input logic [SIL_W-1:0] p);
      if (p == '0)
         return s >= LOSS_INIT_CYC;
      return {1'b0, s} > {p, 1'b0};
   endfunction

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lost_ff <= 2'h0; // R23
      end else begin
         for (int k = 0; k < 2; k++)
            if (rise[k])
               lost_ff[k] <= 1'b0; // R19
            else if (silent(sil_ff[k], per_ff[k]))
               lost_ff[k] <= 1'b1; // R14
      end
   end

   assign ref0_lost_flag_o = lost_ff[0]; // R11
   assign ref1_lost_flag_o = lost_ff[1];
   assign active_sel_o = sel_ff;

   // ---------------- Switchover state machine ----------------
   logic req_q_ff;
   logic man_rise;
   logic auto_go;

   assign man_rise = switch_req_i && !req_q_ff; // R17 R20
   // A held request masks the automatic path
   assign auto_go = !switch_req_i && lost_ff[sel_ff] && !lost_ff[!sel_ff]; // R10 R22

   always_ff @(posedge clk_i) begin
      if (rst_i)
         req_q_ff <= 1'b0;
      else
         req_q_ff <= switch_req_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= SW_RUN;
         sel_ff <= 1'b0; // R23
         gated_ff <= 1'b0;
      end else begin
         case (st_ff)
            SW_RUN: begin
               if (man_rise || auto_go) // R12 R15
                  st_ff <= SW_GATE;
            end
            SW_GATE: begin
               // A dead old input never falls, so loss gates at once
               if (fall[sel_ff] || lost_ff[sel_ff]) begin // R18
                  gated_ff <= 1'b1;
                  st_ff <= SW_LAND;
               end
            end
            SW_LAND: begin
               if (fall[!sel_ff] && !lost_ff[!sel_ff]) begin // R16 R18 R21
                  sel_ff <= !sel_ff;
                  gated_ff <= 1'b0;
                  st_ff <= SW_RUN;
               end
            end
            default: st_ff <= SW_RUN;
         endcase
      end
   end

   logic ref_clk_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i)
         ref_clk_ff <= 1'b0;
      else
         ref_clk_ff <= !gated_ff && ref_ff[sel_ff];
   end

   assign ref_clk_o = ref_clk_ff;

   // ---------------- Prescale and feedback ----------------
   logic [DIV_W-1:0] pre_cnt_ff;
   logic [DIV_W-1:0] fb_cnt_ff;
   logic ref_clk_q_ff;
   logic pfd_ref_ff;
   logic pfd_fb_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_clk_q_ff <= 1'b0;
         pre_cnt_ff <= '0;
         pfd_ref_ff <= 1'b0;
      end else begin
         ref_clk_q_ff <= ref_clk_ff;
         pfd_ref_ff <= 1'b0;
         if (ref_clk_ff && !ref_clk_q_ff) begin
            // Pulse only, no duty shaping
            if (pre_cnt_ff + 10'h001 >= pre_ff) begin // R02
               pre_cnt_ff <= '0;
               pfd_ref_ff <= 1'b1;
            end else begin
               pre_cnt_ff <= pre_cnt_ff + 10'h001;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fb_cnt_ff <= '0;
         pfd_fb_ff <= 1'b0;
      end else begin
         pfd_fb_ff <= 1'b0;
         if (vco_tick_i) begin
            if (fb_cnt_ff + 10'h001 >= fb_ff) begin // R01
               fb_cnt_ff <= '0;
               pfd_fb_ff <= 1'b1;
            end else begin
               fb_cnt_ff <= fb_cnt_ff + 10'h001;
            end
         end
      end
   end

   assign pfd_ref_o = pfd_ref_ff;
   assign pfd_fb_o = pfd_fb_ff;

   // ---------------- Output dividers ----------------
   // Counting half periods gives a duty step of one half over the divide value
   logic [N_OUT-1:0] oclk_ff;
   logic [N_OUT-1:0] oclk_q_ff;
   logic [N_OUT-1:0] otick;
   logic [DIV_W:0] ocnt_ff [N_OUT];

   always_comb begin
      for (int i = 0; i < N_OUT; i++)
         if (i > 0 && CASCADE[i]) // R07 R08
            otick[i] = oclk_ff[(i + N_OUT - 1) % N_OUT] != oclk_q_ff[(i + N_OUT - 1) % N_OUT];
         else
            otick[i] = vco_tick_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oclk_ff <= '0;
         oclk_q_ff <= '0;
         for (int i = 0; i < N_OUT; i++)
            ocnt_ff[i] <= '0;
      end else begin
         oclk_q_ff <= oclk_ff;
         for (int i = 0; i < N_OUT; i++) begin
            if (otick[i]) begin
               // Period in half ticks is high plus low, twice the divide value
               if (ocnt_ff[i] + 11'h001 >= {odiv_ff[i].div, 1'b0}) begin // R06
                  ocnt_ff[i] <= '0;
                  oclk_ff[i] <= 1'b1;
               end else begin
                  ocnt_ff[i] <= ocnt_ff[i] + 11'h001;
                  if (odiv_ff[i].half_duty) // R04
                     oclk_ff[i] <= (ocnt_ff[i] + 11'h001) < {1'b0, odiv_ff[i].div};
                  else // R09
                     oclk_ff[i] <= (ocnt_ff[i] + 11'h001) < {1'b0, odiv_ff[i].high_half};
               end
            end
         end
      end
   end

   assign global_clock_network_o = oclk_ff; // R03

   // ---------------- Assertions ----------------
   a_lost_on_silence: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(lost_ff[0]) |-> $past(silent(sil_ff[0], per_ff[0]))) // R14
      else $error("ref0 lost flag rose without silence");

   a_clear_on_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      rise[0] |=> !lost_ff[0]) // R19
      else $error("ref0 lost flag stayed set after an edge");

   a_switch_on_fall: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(sel_ff) |-> $past(st_ff) == SW_LAND && $past(fall[!sel_ff])) // R16
      else $error("select changed outside a falling edge of the new input");

   a_gated_in_land: assert property (@(posedge clk_i) disable iff (rst_i)
      st_ff == SW_LAND |-> gated_ff ##0 (gated_ff throughout (st_ff == SW_LAND))) // R18
      else $error("reference not gated while landing");

   a_gate_silences_out: assert property (@(posedge clk_i) disable iff (rst_i)
      gated_ff |=> !ref_clk_ff) // R18
      else $error("gated reference still toggling");

   a_held_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_ff == SW_RUN && switch_req_i && req_q_ff) |=> st_ff == SW_RUN) // R22
      else $error("switch started while request held");

   a_prescale_range: assert property (@(posedge clk_i) disable iff (rst_i)
      pre_ff >= DIV_MIN && pre_ff <= DIV_MAX && fb_ff >= DIV_MIN && fb_ff <= DIV_MAX) // R01
      else $error("prescale or feedback out of range");

   a_skew_limit: assert property (@(posedge clk_i) disable iff (rst_i)
      !odiv_ff[2].half_duty |-> odiv_ff[2].div <= DIV_MAX_SKEW) // R05
      else $error("skewed duty divider above limit");

   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_ff |=> !ack_ff)
      else $error("ack held longer than one cycle");

   a_auto_start: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_ff == SW_RUN && auto_go) |=> st_ff == SW_GATE) // R10
      else $error("loss did not start a switch");

   a_manual_start: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_ff == SW_RUN && man_rise) |=> st_ff == SW_GATE) // R17
      else $error("request edge did not start a switch");

   a_idle_no_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      st_ff == SW_RUN |-> !gated_ff) // R18
      else $error("reference gated while idle");

endmodule // pllsw_top

// ==== tb_pll_ref_switchover_and_dividers.sv ====
`timescale 1ns/1ps
module tb_pll_ref_switchover_and_dividers;
   import pllsw_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic switch_req_i = 1'b0;
   logic run0 = 1'b1;
   logic run1 = 1'b1;
   pllsw_wbreq_t req = '0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, lost0, lost1, act, ref_clk_o, pfd_ref_o, pfd_fb_o, ref0, ref1;
   logic [N_OUT-1:0] gcn;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   wire logic [6:0] mon = {gcn, pfd_fb_o, pfd_ref_o};
   wire logic [2:0] st = {act, lost1, lost0};
   always #12.5 clk_i = ~clk_i;
   // Same rate on both sources so loss sensing stays valid
   pllsw_ref_src #(.HALF(4)) src0 (.clk_i(clk_i), .run_i(run0), .ref_o(ref0));
   pllsw_ref_src #(.HALF(4)) src1 (.clk_i(clk_i), .run_i(run1), .ref_o(ref1));
   pllsw_top #(.CASCADE(5'h02)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .primary_ref_clock_i(ref0),
      .secondary_ref_clock_i(ref1), .switch_req_i(switch_req_i), .vco_tick_i(1'b1),
      .ref0_lost_flag_o(lost0), .ref1_lost_flag_o(lost1), .active_sel_o(act),
      .ref_clk_o(ref_clk_o), .pfd_ref_o(pfd_ref_o), .pfd_fb_o(pfd_fb_o),
      .global_clock_network_o(gcn));
   task results;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         results();
      end
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
           output logic [31:0] q);
      int n;
      n = 0;
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      if (n >= 50) chk("bus ack", 32'h1, 32'h0);
      req <= '0;
      @(posedge clk_i);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] q;
      wb(1'b1, a, d, s, q);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, 4'hF, q);
      chk(nm, e, q);
   endtask
   // Until mode stops at the first match; stay mode flags any departure
   task watch(input int b, input logic v, input int n, input bit stay, input string nm);
      logic seen;
      seen = st[b];
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         if (stay && st[b] !== v) seen = st[b];
         if (!stay) seen = st[b];
         if (!stay && seen === v) break;
      end
      chk(nm, {31'h0, v}, {31'h0, seen});
   endtask
   task measure(input int b, input int eh, input int ep, input string nm);
      int hi, per, n;
      hi = 0;
      n = 0;
      while (mon[b] !== 1'b0 && n < 4000) begin @(posedge clk_i); n++; end
      while (mon[b] !== 1'b1 && n < 4000) begin @(posedge clk_i); n++; end
      while (mon[b] === 1'b1 && n < 4000) begin @(posedge clk_i); hi++; n++; end
      per = hi;
      while (mon[b] === 1'b0 && n < 4000) begin @(posedge clk_i); per++; n++; end
      chk({nm, " high"}, eh, hi);
      chk({nm, " period"}, ep, per);
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(OFS_STATUS, 32'h0, "status after reset");
      rd(OFS_PRESCALE, 32'h1, "prescale reset");
      rd(OFS_FEEDBACK, 32'h1, "feedback reset");
      for (int i = 0; i < N_OUT; i++) rd(OFS_ODIV0 + ODIV_STRIDE * 8'(i), 32'h100401, "odiv");
      rd(OFS_CASCADE, 32'h2, "cascade");
      wr(OFS_CASCADE, 32'h0, 4'hF);
      rd(OFS_CASCADE, 32'h2, "cascade fixed");
      rd(8'h40, 32'h0, "unmapped");
      wr(OFS_PRESCALE, 32'h200, 4'hF);
      rd(OFS_PRESCALE, 32'h200, "prescale max");
      wr(OFS_PRESCALE, 32'h201, 4'hF);
      wr(OFS_PRESCALE, 32'h0, 4'hF);
      wr(OFS_PRESCALE, 32'h3, 4'h3);
      rd(OFS_PRESCALE, 32'h200, "prescale refused");
      wr(OFS_ODIV0 + 8'h10, 32'h100600, 4'hF);
      rd(OFS_ODIV0 + 8'h10, 32'h100600, "half duty 512");
      wr(OFS_ODIV0 + 8'h0C, 32'h501, 4'hF);
      wr(OFS_ODIV0 + 8'h0C, 32'h2004, 4'hF);
      rd(OFS_ODIV0 + 8'h0C, 32'h100401, "skew refused");
      wr(OFS_ODIV0 + 8'h08, 32'hC04, 4'hF);
      rd(OFS_ODIV0 + 8'h08, 32'hC04, "skew accepted");
      wr(OFS_PRESCALE, 32'h3, 4'hF);
      wr(OFS_FEEDBACK, 32'h5, 4'hF);
      wr(OFS_ODIV0, 32'h100402, 4'hF);
      wr(OFS_ODIV0 + 8'h04, 32'h100403, 4'hF);
      repeat (100) @(posedge clk_i);
      measure(0, 1, 24, "prescale");
      measure(1, 1, 5, "feedback");
      measure(2, 2, 4, "odiv0");
      measure(3, 6, 12, "cascade");
      measure(4, 3, 8, "odiv2 skew");
      measure(5, 1, 2, "odiv3 min");
      measure(6, 512, 1024, "odiv4 max");
      $display("test registers and dividers done");
      switch_req_i <= 1'b1;
      watch(2, 1'b1, 100, 1'b0, "manual to secondary");
      repeat (30) @(posedge clk_i);
      rd(OFS_STATUS, 32'h4, "manual status");
      switch_req_i <= 1'b0;
      watch(2, 1'b1, 60, 1'b1, "no switch back");
      switch_req_i <= 1'b1;
      watch(2, 1'b0, 100, 1'b0, "second edge");
      repeat (30) @(posedge clk_i);
      switch_req_i <= 1'b0;
      $display("test manual switch done");
      run0 <= 1'b0;
      watch(0, 1'b1, 100, 1'b0, "primary lost");
      watch(2, 1'b1, 100, 1'b0, "auto to secondary");
      run0 <= 1'b1;
      watch(0, 1'b0, 100, 1'b0, "primary back");
      run1 <= 1'b0;
      watch(2, 1'b0, 100, 1'b0, "auto to primary");
      run1 <= 1'b1;
      watch(1, 1'b0, 100, 1'b0, "secondary back");
      $display("test auto switch done");
      run1 <= 1'b0;
      watch(1, 1'b1, 100, 1'b0, "secondary lost");
      switch_req_i <= 1'b1;
      watch(2, 1'b0, 60, 1'b1, "waits for target");
      rd(OFS_STATUS, 32'h2A, "waiting status");
      repeat (16) begin
         @(posedge clk_i);
         chk("gated ref", 32'h0, {31'h0, ref_clk_o});
      end
      run1 <= 1'b1;
      watch(2, 1'b1, 100, 1'b0, "completes later");
      run1 <= 1'b0;
      watch(1, 1'b1, 100, 1'b0, "lost while held");
      watch(2, 1'b1, 80, 1'b1, "auto blocked");
      switch_req_i <= 1'b0;
      watch(2, 1'b0, 100, 1'b0, "auto after release");
      run1 <= 1'b1;
      $display("test unavailable and override done");
      results();
   end
endmodule // tb_pll_ref_switchover_and_dividers
